// [logic/cea_top.sv]
// Carrying and extended add datapath behind an APB register slave
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Carrying add writes source sum to target
// - Primary 31, extended 10 selects carrying add
// - Extended add also adds current spill flag
// - Primary 31, extended 138 selects extended add
// - Target, sources, overflow-enable, record from fixed fields
// - Every form loads the spill flag
// - Overflow-enable updates wrap and summary flags
// - Record sets condition field 0 plus summary
// - Flags untouched when their enable bit clear
module cea_top
	import cea_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [CEA_PADDR_W-1:0] paddr,
	input wire logic [CEA_DATA_W-1:0] pwdata,
	output wire logic pready,
	output wire logic [CEA_DATA_W-1:0] prdata,
	output wire logic pslverr
);
	// ============================================================
	// Decode: bit 1 is a valid add, bit 0 marks the extended form
	function automatic logic [1:0] cea_decode(input logic [31:0] w);
		logic prim;
		prim = (w[CEA_OPC_HI:CEA_OPC_LO] == CEA_PRIMARY_OP);
		if (prim && w[CEA_XOP_HI:CEA_XOP_LO] == CEA_XOP_CARRYING)
			cea_decode = 2'h2;
		else if (prim && w[CEA_XOP_HI:CEA_XOP_LO] == CEA_XOP_EXTENDED)
			cea_decode = 2'h3;
		else
			cea_decode = 2'h0;
	endfunction

	cea_gpr_if gpr ();
	cea_gpr_mem u_mem (.pclk(pclk), .presetn(presetn), .gpr(gpr.mem));

	cea_state_t state_ff;
	logic [CEA_DATA_W-1:0] instr_ff;
	logic is_ext_ff;
	logic spill_ff;
	logic wrap_ff;
	logic summary_ff;
	logic [CEA_CR_W-1:0] cr0_ff;
	logic [CEA_GPR_AW-1:0] index_ff;
	logic illegal_ff;
	logic settle_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [CEA_DATA_W-1:0] prdata_ff;

	// ============================================================
	// APB handshake terms
	logic idle;
	logic answer;
	logic commit;
	logic wr_commit;
	logic [1:0] dec_w;
	logic start;
	logic gpr_touch;

	assign idle = (state_ff == CEA_IDLE);
	assign answer = psel && penable && !pready_ff && idle && settle_ff;
	assign commit = psel && penable && pready_ff;
	assign wr_commit = commit && pwrite;
	assign dec_w = cea_decode(pwdata);
	assign start = wr_commit && (paddr == CEA_OFS_INSTR) && dec_w[1];
	assign gpr_touch = wr_commit && (paddr == CEA_OFS_GPR_IDX ||
		paddr == CEA_OFS_GPR_DATA);

	// ============================================================
	// Instruction fields
	logic [CEA_GPR_AW-1:0] tgt_field;
	logic [CEA_GPR_AW-1:0] source_a_field;
	logic [CEA_GPR_AW-1:0] source_b_field;
	logic oven_bit;
	logic record_bit;

	assign tgt_field = instr_ff[CEA_TGT_HI:CEA_TGT_LO];
	assign source_a_field = instr_ff[CEA_SRCA_HI:CEA_SRCA_LO];
	assign source_b_field = instr_ff[CEA_SRCB_HI:CEA_SRCB_LO];
	assign oven_bit = instr_ff[CEA_OVEN_BIT];
	assign record_bit = instr_ff[CEA_REC_BIT];

	// ============================================================
	// Adder
	logic exec;
	logic carry_in;
	logic [CEA_DATA_W:0] sum_wide;
	logic [CEA_DATA_W-1:0] result;
	logic carry_out;
	logic wrap;
	logic nxt_summary;

	assign exec = (state_ff == CEA_EXEC);
	assign carry_in = is_ext_ff & spill_ff;
	assign sum_wide = {1'b0, gpr.ra_data} + {1'b0, gpr.rb_data} +
		{{CEA_DATA_W{1'b0}}, carry_in};
	assign result = sum_wide[CEA_DATA_W-1:0];
	assign carry_out = sum_wide[CEA_DATA_W];
	assign wrap = (gpr.ra_data[CEA_DATA_W-1] == gpr.rb_data[CEA_DATA_W-1])
		&& (result[CEA_DATA_W-1] != gpr.ra_data[CEA_DATA_W-1]);
	assign nxt_summary = oven_bit ? (summary_ff | wrap) : summary_ff;

	// ============================================================
	// Register file port steering
	assign gpr.ra_addr = idle ? index_ff : source_a_field;
	assign gpr.rb_addr = source_b_field;
	assign gpr.we = exec || (wr_commit && paddr == CEA_OFS_GPR_DATA);
	assign gpr.waddr = exec ? tgt_field : index_ff;
	assign gpr.wdata = exec ? result : pwdata;

	// ============================================================
	// Sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= CEA_IDLE;
		end
		else
		begin
			case (state_ff)
				CEA_IDLE:
					if (start)
						state_ff <= CEA_READ;
				CEA_READ:
					state_ff <= CEA_EXEC;
				CEA_EXEC:
					state_ff <= CEA_IDLE;
				default:
					state_ff <= CEA_IDLE;
			endcase
		end
	end

	// Latch of the issued word and its decode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_ff <= '0;
			is_ext_ff <= 1'b0;
			illegal_ff <= 1'b0;
		end
		else if (wr_commit && paddr == CEA_OFS_INSTR)
		begin
			instr_ff <= pwdata;
			is_ext_ff <= dec_w[0];
			illegal_ff <= !dec_w[1];
		end
	end

	// Read port settles one cycle after any change of its address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			settle_ff <= 1'b0;
			index_ff <= '0;
		end
		else
		begin
			settle_ff <= idle && !gpr_touch && !start;
			if (wr_commit && paddr == CEA_OFS_GPR_IDX)
				index_ff <= pwdata[CEA_GPR_AW-1:0];
		end
	end

	// ============================================================
	// Fixed-point flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			spill_ff <= 1'b0;
			wrap_ff <= 1'b0;
			summary_ff <= 1'b0;
		end
		else if (exec)
		begin
			spill_ff <= carry_out;
			if (oven_bit)
			begin
				wrap_ff <= wrap;
				summary_ff <= nxt_summary;
			end
		end
		else if (wr_commit && paddr == CEA_OFS_XFLAGS)
		begin
			spill_ff <= pwdata[CEA_XF_SPILL];
			wrap_ff <= pwdata[CEA_XF_WRAP];
			summary_ff <= pwdata[CEA_XF_SUMMARY];
		end
	end

	// Condition field 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cr0_ff <= '0;
		end
		else if (exec && record_bit)
		begin
			cr0_ff[CEA_CR_BELOW] <= result[CEA_DATA_W-1];
			cr0_ff[CEA_CR_ABOVE] <= !result[CEA_DATA_W-1] && |result;
			cr0_ff[CEA_CR_ZERO] <= (result == '0);
			cr0_ff[CEA_CR_SUMMARY] <= nxt_summary;
		end
		else if (!exec && wr_commit && paddr == CEA_OFS_CR0)
		begin
			cr0_ff <= pwdata[CEA_CR_W-1:0];
		end
	end

	// ============================================================
	// APB answer: one wait state, stalls while an add is running
	logic [CEA_DATA_W-1:0] nxt_prdata;
	logic nxt_pslverr;

	always_comb
	begin
		nxt_prdata = '0;
		nxt_pslverr = 1'b0;
		case (paddr)
			CEA_OFS_INSTR:
				nxt_prdata = instr_ff;
			CEA_OFS_XFLAGS:
			begin
				nxt_prdata[CEA_XF_SPILL] = spill_ff;
				nxt_prdata[CEA_XF_WRAP] = wrap_ff;
				nxt_prdata[CEA_XF_SUMMARY] = summary_ff;
			end
			CEA_OFS_CR0:
				nxt_prdata[CEA_CR_W-1:0] = cr0_ff;
			CEA_OFS_GPR_IDX:
				nxt_prdata[CEA_GPR_AW-1:0] = index_ff;
			CEA_OFS_GPR_DATA:
				nxt_prdata = gpr.ra_data;
			CEA_OFS_STATUS:
				nxt_prdata[0] = illegal_ff;
			default:
				nxt_pslverr = 1'b1;
		endcase
		if (pwrite)
			nxt_prdata = '0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= answer;
			prdata_ff <= answer ? nxt_prdata : '0;
			pslverr_ff <= answer && nxt_pslverr;
		end
	end

	assign pready = pready_ff;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	// ============================================================
	// Checks
	logic [CEA_DATA_W:0] chk_sum;
	assign chk_sum = {1'b0, gpr.ra_data} + {1'b0, gpr.rb_data} +
		{{CEA_DATA_W{1'b0}}, is_ext_ff & spill_ff};

	sequence s_issue;
		idle && start;
	endsequence
	sequence s_run;
		state_ff == CEA_READ ##1 state_ff == CEA_EXEC ##1 idle;
	endsequence

	chk_issue_run: assert property (
		@(posedge pclk) disable iff (!presetn) s_issue |=> s_run)
		else $error("issued add did not run read then execute");
	chk_carry_decode: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_commit && paddr == CEA_OFS_INSTR &&
		pwdata[CEA_OPC_HI:CEA_OPC_LO] == CEA_PRIMARY_OP &&
		pwdata[CEA_XOP_HI:CEA_XOP_LO] == CEA_XOP_CARRYING
		|=> state_ff == CEA_READ && !is_ext_ff)
		else $error("carrying add not decoded");
	chk_ext_decode: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_commit && paddr == CEA_OFS_INSTR &&
		pwdata[CEA_OPC_HI:CEA_OPC_LO] == CEA_PRIMARY_OP &&
		pwdata[CEA_XOP_HI:CEA_XOP_LO] == CEA_XOP_EXTENDED
		|=> state_ff == CEA_READ && is_ext_ff)
		else $error("extended add not decoded");
	chk_src_fields: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_ff == CEA_READ |-> gpr.ra_addr == instr_ff[20:16] &&
		gpr.rb_addr == instr_ff[15:11])
		else $error("source fields taken from wrong bits");
	chk_sum_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		exec |-> gpr.we && gpr.waddr == instr_ff[25:21] &&
		gpr.wdata == chk_sum[31:0])
		else $error("target not written with the sum");
	chk_spill_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		exec |=> spill_ff == $past(chk_sum[32]))
		else $error("spill flag not loaded from carry out");
	chk_wrap_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		exec && instr_ff[10] |=> wrap_ff == $past(
		gpr.ra_data[31] == gpr.rb_data[31] &&
		chk_sum[31] != gpr.ra_data[31]))
		else $error("wrap flag not signed overflow");
	chk_flags_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		exec && !instr_ff[10] |=> $stable(wrap_ff) && $stable(summary_ff))
		else $error("wrap or summary changed without enable");
	chk_cr0_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		exec && !instr_ff[0] |=> $stable(cr0_ff))
		else $error("condition field changed without record");
	chk_cr0_record: assert property (
		@(posedge pclk) disable iff (!presetn)
		exec && instr_ff[0] |=> cr0_ff[0] == summary_ff &&
		cr0_ff[1] == ($past(chk_sum[31:0]) == 0) &&
		cr0_ff[3] == $past(chk_sum[31]))
		else $error("condition field not set from result");
	chk_summary_sticky: assert property (
		@(posedge pclk) disable iff (!presetn)
		summary_ff && !(wr_commit && paddr == CEA_OFS_XFLAGS)
		|=> summary_ff)
		else $error("summary overflow cleared by an add");
endmodule
`default_nettype wire

// [logic/cea_pkg.sv]
// Constants, field layout and state codes of the carrying and extended adder
package cea_pkg;
	// ============================================================
	// Data and bus widths
	localparam int CEA_DATA_W = 32;
	localparam int CEA_GPR_AW = 5;
	localparam int CEA_PADDR_W = 8;

	// ============================================================
	// Register byte offsets
	localparam logic [7:0] CEA_OFS_INSTR = 8'h00;
	localparam logic [7:0] CEA_OFS_XFLAGS = 8'h04;
	localparam logic [7:0] CEA_OFS_CR0 = 8'h08;
	localparam logic [7:0] CEA_OFS_GPR_IDX = 8'h0c;
	localparam logic [7:0] CEA_OFS_GPR_DATA = 8'h10;
	localparam logic [7:0] CEA_OFS_STATUS = 8'h14;

	// ============================================================
	// Fixed-point flag register bit positions
	localparam int CEA_XF_SPILL = 0;
	localparam int CEA_XF_WRAP = 1;
	localparam int CEA_XF_SUMMARY = 2;
	// Condition field 0 bit positions
	localparam int CEA_CR_BELOW = 3;
	localparam int CEA_CR_ABOVE = 2;
	localparam int CEA_CR_ZERO = 1;
	localparam int CEA_CR_SUMMARY = 0;
	localparam int CEA_CR_W = 4;

	// ============================================================
	// Instruction word fields; bit 31 of the word is the most significant
	localparam int CEA_OPC_HI = 31;
	localparam int CEA_OPC_LO = 26;
	localparam int CEA_TGT_HI = 25;
	localparam int CEA_TGT_LO = 21;
	localparam int CEA_SRCA_HI = 20;
	localparam int CEA_SRCA_LO = 16;
	localparam int CEA_SRCB_HI = 15;
	localparam int CEA_SRCB_LO = 11;
	localparam int CEA_OVEN_BIT = 10;
	localparam int CEA_XOP_HI = 9;
	localparam int CEA_XOP_LO = 1;
	localparam int CEA_REC_BIT = 0;

	// ============================================================
	// Opcode values
	localparam logic [5:0] CEA_PRIMARY_OP = 6'h1f;
	localparam logic [8:0] CEA_XOP_CARRYING = 9'h00a;
	localparam logic [8:0] CEA_XOP_EXTENDED = 9'h08a;

	// ============================================================
	// Sequencer states
	typedef enum logic [2:0]
	{
		CEA_IDLE = 3'b001,
		CEA_READ = 3'b010,
		CEA_EXEC = 3'b100
	} cea_state_t;
endpackage

// [logic/cea_gpr_if.sv]
// Carrier between the adder control and its register file
`timescale 1ns/10ps
`default_nettype none
interface cea_gpr_if;
	import cea_pkg::*;
	logic we;
	logic [CEA_GPR_AW-1:0] waddr;
	logic [CEA_DATA_W-1:0] wdata;
	logic [CEA_GPR_AW-1:0] ra_addr;
	logic [CEA_GPR_AW-1:0] rb_addr;
	logic [CEA_DATA_W-1:0] ra_data;
	logic [CEA_DATA_W-1:0] rb_data;

	modport ctrl (output we, waddr, wdata, ra_addr, rb_addr,
		input ra_data, rb_data);
	modport mem (input we, waddr, wdata, ra_addr, rb_addr,
		output ra_data, rb_data);
endinterface
`default_nettype wire

// [logic/cea_gpr_mem.sv]
// General-purpose register file: two registered read ports, one write port
`timescale 1ns/10ps
`default_nettype none
module cea_gpr_mem
	import cea_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	cea_gpr_if.mem gpr
);
	logic [CEA_DATA_W-1:0] store [0:(1<<CEA_GPR_AW)-1];

	// ============================================================
	// Write port
	always_ff @(posedge pclk)
	begin
		if (gpr.we)
		begin
			store[gpr.waddr] <= gpr.wdata;
		end
	end

	// ============================================================
	// Read ports return the old word on a same-cycle write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gpr.ra_data <= '0;
			gpr.rb_data <= '0;
		end
		else
		begin
			gpr.ra_data <= store[gpr.ra_addr];
			gpr.rb_data <= store[gpr.rb_addr];
		end
	end
endmodule
`default_nettype wire

// [sim/cea_issue_model.sv]
// APB master model standing in for the instruction issue logic
`timescale 1ns/10ps
`default_nettype none
module cea_issue_model
	import cea_pkg::*;
(
	input wire logic pclk,
	input wire logic pready,
	input wire logic [CEA_DATA_W-1:0] prdata,
	input wire logic pslverr,
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [CEA_PADDR_W-1:0] paddr,
	output var logic [CEA_DATA_W-1:0] pwdata
);
	logic [CEA_DATA_W-1:0] rd_data;
	logic rd_err;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// ============================================================
	// One transfer; no latency assumed, the bench watchdog cuts hangs
	task automatic xfer(input logic wr, input logic [CEA_PADDR_W-1:0] addr,
		input logic [CEA_DATA_W-1:0] data);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines do not keep their last value
		paddr <= ~addr;
		pwdata <= ~data;
	endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the carrying and extended adder
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import cea_pkg::*;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [CEA_PADDR_W-1:0] paddr;
	logic [CEA_DATA_W-1:0] pwdata;
	logic pready;
	logic [CEA_DATA_W-1:0] prdata;
	logic pslverr;
	int n_errors = 0;
	int check_count = 0;

	cea_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));
	cea_issue_model u_host (.pclk(pclk), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
	end
	always #2.5 pclk = ~pclk;

	// ============================================================
	// Checking and closing
	task automatic chk_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp,
		input logic got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ============================================================
	// Register access helpers
	task automatic rd_chk(input string what, input logic [7:0] addr,
		input logic [31:0] exp);
		u_host.xfer(1'b0, addr, 32'h0000_0000);
		chk_word(what, exp, u_host.rd_data);
	endtask

	task automatic set_gpr(input logic [4:0] idx, input logic [31:0] val);
		u_host.xfer(1'b1, CEA_OFS_GPR_IDX, {27'h0, idx});
		u_host.xfer(1'b1, CEA_OFS_GPR_DATA, val);
	endtask

	task automatic gpr_chk(input logic [4:0] idx, input logic [31:0] exp);
		u_host.xfer(1'b1, CEA_OFS_GPR_IDX, {27'h0, idx});
		rd_chk("target", CEA_OFS_GPR_DATA, exp);
	endtask

	// Loads sources, issues one add, checks target, flags and field 0
	task automatic do_add(input logic [8:0] xop, input logic [4:0] t,
		input logic [4:0] a, input logic [4:0] b, input logic oe,
		input logic rc, input logic [31:0] va, input logic [31:0] vb,
		input logic [31:0] er, input logic [2:0] ex, input logic [3:0] ec);
		set_gpr(a, va);
		set_gpr(b, vb);
		u_host.xfer(1'b1, CEA_OFS_INSTR,
			{CEA_PRIMARY_OP, t, a, b, oe, xop, rc});
		gpr_chk(t, er);
		rd_chk("xflags", CEA_OFS_XFLAGS, {29'h0, ex});
		rd_chk("cr0", CEA_OFS_CR0, {28'h0, ec});
	endtask

	// ============================================================
	// Watchdog
	initial
	begin
		#50000;
		n_errors++;
		$display("Error watchdog expected done seen hang");
		wrap_up();
	end

	// ============================================================
	// Main sequence
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("xflags reset", CEA_OFS_XFLAGS, 32'h0000_0000);
		rd_chk("cr0 reset", CEA_OFS_CR0, 32'h0000_0000);
		do_add(CEA_XOP_CARRYING, 5'h06, 5'h04, 5'h0a, 1'b0, 1'b0, 32'h9000_3000,
			32'h8000_7000, 32'h1000_a000, 3'b001, 4'h0);
		rd_chk("status legal", CEA_OFS_STATUS, 32'h0000_0000);
		chk_bit("mapped err", 1'b0, u_host.rd_err);
		do_add(CEA_XOP_EXTENDED, 5'h07, 5'h03, 5'h0c, 1'b1, 1'b1, 32'h1000_0400,
			32'hefff_ffff, 32'h0000_0400, 3'b001, 4'h4);
		do_add(CEA_XOP_EXTENDED, 5'h1f, 5'h00, 5'h1e, 1'b1, 1'b1, 32'h8000_0000,
			32'h8000_7000, 32'h0000_7001, 3'b111, 4'h5);
		do_add(CEA_XOP_CARRYING, 5'h01, 5'h02, 5'h05, 1'b0, 1'b1, 32'h8000_0000,
			32'h0000_0001, 32'h8000_0001, 3'b110, 4'h9);
		do_add(CEA_XOP_EXTENDED, 5'h08, 5'h09, 5'h09, 1'b1, 1'b0, 32'h0000_0000,
			32'h0000_0000, 32'h0000_0000, 3'b100, 4'h9);
		// Software clears summary and sets spill for the next extended add
		u_host.xfer(1'b1, CEA_OFS_XFLAGS, 32'h0000_0001);
		rd_chk("xflags write", CEA_OFS_XFLAGS, 32'h0000_0001);
		u_host.xfer(1'b1, CEA_OFS_CR0, 32'h0000_0006);
		rd_chk("cr0 write", CEA_OFS_CR0, 32'h0000_0006);
		do_add(CEA_XOP_EXTENDED, 5'h0b, 5'h0d, 5'h0e, 1'b0, 1'b0, 32'h1000_0400,
			32'h1000_0400, 32'h2000_0801, 3'b000, 4'h6);
		// Plain add opcode must not execute here
		set_gpr(5'h06, 32'h1234_5678);
		u_host.xfer(1'b1, CEA_OFS_INSTR, {CEA_PRIMARY_OP, 5'h06, 5'h04,
			5'h0a, 1'b0, 9'h10a, 1'b0});
		rd_chk("status", CEA_OFS_STATUS, 32'h0000_0001);
		gpr_chk(5'h06, 32'h1234_5678);
		rd_chk("gpr index", CEA_OFS_GPR_IDX, 32'h0000_0006);
		rd_chk("instr", CEA_OFS_INSTR, {CEA_PRIMARY_OP, 5'h06, 5'h04,
			5'h0a, 1'b0, 9'h10a, 1'b0});
		u_host.xfer(1'b0, 8'h18, 32'h0000_0000);
		chk_bit("unmapped err", 1'b1, u_host.rd_err);
		chk_word("unmapped data", 32'h0000_0000, u_host.rd_data);
		wrap_up();
	end
endmodule
`default_nettype wire
